// >>> core/reset_sequencer_prescaler.v
// Purpose: reset sequencer with prescale counter and cause register
// Assumes: CLK is the oscillator clock, APB slave for registers
// Notes:   prescaler runs on the falling edge of CLK
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"
module reset_sequencer_prescaler #(
	parameter PIN_POR_CYCLES = `PIN_POR_CYCLES
)(
	input  wire                  CLK,
	input  wire                  RST_N,
	input  wire                  PSEL,
	input  wire                  PENABLE,
	input  wire                  PWRITE,
	input  wire [`ADDR_BITS-1:0] PADDR,
	input  wire [31:0]           PWDATA,
	output reg  [31:0]           PRDATA,
	output reg                   PREADY,
	output reg                   PSLVERR,
	input  wire                  POWER_UP_PULSE,
	input  wire                  RST_PIN_IN,
	output reg                   RST_PIN_OUT,
	output reg                   RST_PIN_OE_N,
	input  wire                  WDOG_OVERFLOW,
	output reg                   WDOG_TICK,
	output reg                   WDOG_CLEAR,
	output reg                   WDOG_DISABLE,
	input  wire                  MONITOR_MODE,
	input  wire                  BREAK_STATE,
	input  wire                  HV_RST_PIN,
	input  wire                  HV_IRQ_PIN,
	input  wire                  BAD_OPCODE,
	input  wire                  STOP_EXEC,
	input  wire                  STOP_EXIT,
	input  wire                  FETCH_UNMAPPED,
	input  wire                  OPCODE_FETCH,
	input  wire                  USB_DP,
	input  wire                  USB_DM,
	input  wire                  USB_SUSPENDED,
	input  wire                  USB_ADDRESS_SET,
	output reg                   USB_UNADDRESSED,
	output reg                   USB_WAKE,
	output reg                   INTERNAL_RESET,
	output reg                   BUS_CLOCK_EN,
	output reg  [15:0]           RESET_VECTOR
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [2:0] S_RUN   = 3'h0;
	localparam [2:0] S_POR   = 3'h1;
	localparam [2:0] S_DRIVE = 3'h2;
	localparam [2:0] S_HOLD  = 3'h3;
	localparam [2:0] S_PIN   = 3'h4;
	localparam [2:0] S_STOP  = 3'h5;
	localparam [2:0] S_WAKE  = 3'h6;

	localparam [17:0] A_CAUSE  = {`IDX_RESET_CAUSE, 2'b00};
	localparam [17:0] A_OPT    = {`IDX_OPTIONS, 2'b00};
	localparam [17:0] A_STATUS = {`IDX_STATUS, 2'b00};
	localparam [17:0] A_SVC    = {`IDX_WDOG_SERVICE, 2'b00};
	localparam [12:0] PIN_POR  = PIN_POR_CYCLES[12:0];

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [6:0]  cnt;
	reg  [6:0]  next_cnt;
	reg  [7:0]  cause;
	reg  [7:0]  next_cause;
	reg         por_seen;
	reg         next_por_seen;
	reg         drive_pin;
	reg         next_drive_pin;
	reg         next_clr_all;
	reg  [12:0] pin_cnt;
	reg  [2:0]  options;
	reg  [11:0] pre;
	reg         stage13;
	reg         pre_clr_all;
	reg         pre_clr_high;
	reg         wd_meta;
	reg         wd_sync;
	reg  [31:0] rdata;
	wire        usb_start;
	wire        usb_end;
	wire        usb_busy;

	// ------------------------------------------------------------
	// request sources
	// ------------------------------------------------------------
	wire se0        = ~USB_DP & ~USB_DM;
	wire stop_en    = options[`OPT_STOP_ENABLE];
	wire short_wake = options[`OPT_SHORT_WAKE];
	// no register can switch the watchdog off, so noise cannot either
	wire wd_off     = (MONITOR_MODE & (HV_RST_PIN | HV_IRQ_PIN)) |
	                  (BREAK_STATE & HV_RST_PIN);
	wire wd_req     = wd_sync & ~wd_off;
	wire opc_req    = BAD_OPCODE | (STOP_EXEC & ~stop_en);
	wire fetch_req  = FETCH_UNMAPPED & OPCODE_FETCH;
	wire int_req    = wd_req | opc_req | fetch_req | usb_start;
	wire pin_low    = ~RST_PIN_IN;
	wire [12:0] pin_thr = por_seen ? PIN_POR : `PIN_LOW_CYCLES;
	wire pin_hit    = pin_low & (pin_cnt == pin_thr - 13'h0001);
	wire wake_done  = short_wake ? pre[`SHORT_WAKE_BIT] : WDOG_TICK;

	usb_reset_detect u_usb (
		.clk         (CLK),
		.rst_n       (RST_N),
		.se0         (se0),
		.reset_start (usb_start),
		.reset_end   (usb_end),
		.in_reset    (usb_busy)
	);

	// ------------------------------------------------------------
	// watchdog overflow synchroniser
	// ------------------------------------------------------------
	// overflow may come from a counter off the bus clock
	always @(posedge CLK) begin
		if (!RST_N) begin
			wd_meta <= 1'b0;
			wd_sync <= 1'b0;
		end else begin
			wd_meta <= WDOG_OVERFLOW;
			wd_sync <= wd_meta;
		end
	end

	// ------------------------------------------------------------
	// prescale counter
	// ------------------------------------------------------------
	// clear requests come from rising-edge flops half a cycle earlier
	always @(negedge CLK) begin
		if (!RST_N) begin
			pre     <= 12'h000;
			stage13 <= 1'b0;
		end else if (pre_clr_all) begin
			pre     <= 12'h000;
			stage13 <= 1'b0;
		end else if (pre_clr_high) begin
			pre     <= {8'h00, pre[3:0]};
			stage13 <= 1'b0;
		end else begin
			{stage13, pre} <= {1'b0, pre} + 13'h0001;
		end
	end

	// thirteenth stage seen once per wrap, one rising edge wide
	always @(posedge CLK) begin
		if (!RST_N) begin
			WDOG_TICK <= 1'b0;
		end else begin
			WDOG_TICK <= stage13;
		end
	end

	// ------------------------------------------------------------
	// sequencer next state
	// ------------------------------------------------------------
	always @* begin
		next_state     = state;
		next_cnt       = cnt + 7'h01;
		next_cause     = cause;
		next_por_seen  = por_seen;
		next_drive_pin = drive_pin;
		next_clr_all   = 1'b0;
		if (pin_hit) begin
			next_cause = por_seen ? (cause | `CAUSE_PIN) : `CAUSE_PIN;
		end
		if (POWER_UP_PULSE) begin
			next_state     = S_POR;
			next_cnt       = 7'h00;
			next_cause     = `CAUSE_RESET;
			next_por_seen  = 1'b1;
			next_drive_pin = 1'b1;
			next_clr_all   = 1'b1;
		end else begin
			case (state)
				S_RUN, S_STOP: begin
					if (int_req) begin
						next_state     = S_DRIVE;
						next_cnt       = 7'h00;
						next_clr_all   = 1'b1;
						next_drive_pin = ~usb_start | wd_req | opc_req | fetch_req;
						if (wd_req) begin
							next_cause = `CAUSE_WDOG;
						end else if (opc_req) begin
							next_cause = `CAUSE_OPCODE;
						end else if (fetch_req) begin
							next_cause = `CAUSE_FETCH;
						end else begin
							next_cause = `CAUSE_USB;
						end
					end else if (state == S_STOP) begin
						if (STOP_EXIT | pin_low) begin
							next_state = S_WAKE;
						end
					end else if (pin_low) begin
						next_state = S_PIN;
					end else if (STOP_EXEC & stop_en) begin
						next_state   = S_STOP;
						next_clr_all = 1'b1;
					end
				end
				S_POR: begin
					if (WDOG_TICK) begin
						next_state = S_DRIVE;
						next_cnt   = 7'h00;
					end
				end
				S_DRIVE: begin
					if (cnt == `DRIVE_CYCLES - 7'h01) begin
						next_state     = S_HOLD;
						next_cnt       = 7'h00;
						next_drive_pin = 1'b0;
					end
				end
				S_HOLD: begin
					if (cnt == `HOLD_CYCLES - 7'h01) begin
						next_state    = pin_low ? S_PIN : S_RUN;
						next_cnt      = 7'h00;
						next_por_seen = pin_low & por_seen;
					end
				end
				S_PIN: begin
					// cnt keeps counting while the pin is held, cleared when the pin is released
					if (!pin_low) begin
						next_state = S_HOLD;
						next_cnt   = 7'h00;
					end
				end
				S_WAKE: begin
					if (wake_done) begin
						next_state = S_RUN;
					end
				end
				default: begin
					next_state = S_RUN;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// sequencer registers and outputs
	// ------------------------------------------------------------
	always @(posedge CLK) begin
		if (!RST_N) begin
			state           <= S_POR;
			cnt             <= 7'h00;
			cause           <= `CAUSE_RESET;
			por_seen        <= 1'b1;
			drive_pin       <= 1'b1;
			pre_clr_all     <= 1'b1;
			pin_cnt         <= 13'h0000;
			RST_PIN_OUT     <= 1'b0;
			RST_PIN_OE_N    <= 1'b0;
			INTERNAL_RESET  <= 1'b1;
			BUS_CLOCK_EN    <= 1'b0;
			RESET_VECTOR    <= `VEC_NORMAL;
			WDOG_DISABLE    <= 1'b0;
			USB_UNADDRESSED <= 1'b1;
			USB_WAKE        <= 1'b0;
		end else begin
			state        <= next_state;
			cnt          <= next_cnt;
			cause        <= next_cause;
			por_seen     <= next_por_seen;
			drive_pin    <= next_drive_pin;
			pre_clr_all  <= next_clr_all;
			RST_PIN_OUT  <= 1'b0;
			// pin pulled low only while this end drives it
			RST_PIN_OE_N <= ~(next_drive_pin & ((next_state == S_POR) |
			                (next_state == S_DRIVE)));
			INTERNAL_RESET <= (next_state == S_POR) | (next_state == S_DRIVE) |
			                  (next_state == S_HOLD) | (next_state == S_PIN);
			BUS_CLOCK_EN <= (next_state != S_POR) & (next_state != S_STOP) &
			                (next_state != S_WAKE);
			RESET_VECTOR <= MONITOR_MODE ? `VEC_MONITOR : `VEC_NORMAL;
			WDOG_DISABLE <= wd_off;
			if (!pin_low) begin
				pin_cnt <= 13'h0000;
			end else if (pin_cnt != PIN_POR) begin
				pin_cnt <= pin_cnt + 13'h0001;
			end
			if (usb_start | usb_busy | usb_end) begin
				USB_UNADDRESSED <= 1'b1;
			end else if (USB_ADDRESS_SET) begin
				USB_UNADDRESSED <= 1'b0;
			end
			if (usb_start & USB_SUSPENDED) begin
				USB_WAKE <= 1'b1;
			end else if (next_state == S_RUN) begin
				USB_WAKE <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// APB register access
	// ------------------------------------------------------------
	wire sel_cause  = (PADDR == A_CAUSE);
	wire sel_opt    = (PADDR == A_OPT);
	wire sel_status = (PADDR == A_STATUS);
	wire sel_svc    = (PADDR == A_SVC);
	wire mapped     = sel_cause | sel_opt | sel_status | sel_svc;
	wire access     = PSEL & PENABLE;

	always @* begin
		if (sel_cause) begin
			rdata = {24'h00_0000, cause};
		end else if (sel_opt) begin
			rdata = {29'h0000_0000, options};
		end else if (sel_status) begin
			rdata = {4'h0, pre, 8'h00, 1'b0, state,
			         1'b0, USB_UNADDRESSED, BUS_CLOCK_EN, INTERNAL_RESET};
		end else begin
			rdata = 32'h0000_0000;
		end
	end

	// one wait state; write lands on the edge that sees pready high
	always @(posedge CLK) begin
		if (!RST_N) begin
			PREADY       <= 1'b0;
			PSLVERR      <= 1'b0;
			PRDATA       <= 32'h0000_0000;
			options      <= `OPT_RESET;
			WDOG_CLEAR   <= 1'b0;
			pre_clr_high <= 1'b0;
		end else begin
			PREADY       <= 1'b0;
			WDOG_CLEAR   <= 1'b0;
			pre_clr_high <= 1'b0;
			if (access & ~PREADY) begin
				PREADY  <= 1'b1;
				PSLVERR <= ~mapped;
				PRDATA  <= PWRITE ? 32'h0000_0000 : rdata;
			end
			if (access & PREADY & PWRITE) begin
				if (sel_opt) begin
					options <= PWDATA[2:0];
				end else if (sel_svc) begin
					WDOG_CLEAR   <= 1'b1;
					pre_clr_high <= 1'b1;
				end
			end
		end
	end
endmodule // reset_sequencer_prescaler
`default_nettype wire

// >>> core/reset_seq_defs.vh
// Purpose: constants for the reset sequencer and prescaler
// Assumes: byte address is four times the register index
// Notes:   definitions only
`ifndef RESET_SEQ_DEFS_VH
`define RESET_SEQ_DEFS_VH
`define ADDR_BITS        18
`define IDX_RESET_CAUSE  16'hFE01
`define IDX_OPTIONS      16'hFE08
`define IDX_STATUS       16'hFE09
`define IDX_WDOG_SERVICE 16'hFFFF
`define VEC_NORMAL       16'hFFFE
`define VEC_MONITOR      16'hFEFE
`define CAUSE_RESET      8'h80
`define CAUSE_PIN        8'h40
`define CAUSE_WDOG       8'h20
`define CAUSE_OPCODE     8'h10
`define CAUSE_FETCH      8'h08
`define CAUSE_USB        8'h04
`define OPT_RESET        3'h0
`define OPT_SHORT_WAKE   0
`define OPT_STOP_ENABLE  1
`define DRIVE_CYCLES     7'h20
`define HOLD_CYCLES      7'h20
`define PIN_LOW_CYCLES   13'h0043
`define PIN_POR_CYCLES   4163
`define SHORT_WAKE_BIT   5
`define CLK_MHZ          10
`define SE0_MIN_NS       2667
`define SE0_CYCLES       ((`SE0_MIN_NS * `CLK_MHZ + 999) / 1000)
`endif

// >>> core/usb_reset_detect.v
// Purpose: recognises a bus reset from a long single-ended zero
// Assumes: se0 is already synchronous to clk
// Notes:   threshold is four low-speed bit times, rounded up
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"
module usb_reset_detect #(
	parameter CNT_W = 6
)(
	input  wire clk,
	input  wire rst_n,
	input  wire se0,
	output reg  reset_start,
	output reg  reset_end,
	output reg  in_reset
);
	localparam integer     LIMIT_FULL = `SE0_CYCLES;
	localparam [CNT_W-1:0] LIMIT      = LIMIT_FULL[CNT_W-1:0];
	reg [CNT_W-1:0] cnt;

	always @(posedge clk) begin
		if (!rst_n) begin
			cnt         <= {CNT_W{1'b0}};
			reset_start <= 1'b0;
			reset_end   <= 1'b0;
			in_reset    <= 1'b0;
		end else begin
			reset_start <= 1'b0;
			reset_end   <= 1'b0;
			if (!se0) begin
				cnt <= {CNT_W{1'b0}};
				if (in_reset) begin
					in_reset  <= 1'b0;
					reset_end <= 1'b1;
				end
			end else if (cnt != LIMIT) begin
				cnt <= cnt + 1'b1;
				// recognised well inside 5.5 us at this threshold
				if (cnt == LIMIT - 1'b1) begin
					in_reset    <= 1'b1;
					reset_start <= 1'b1;
				end
			end
		end
	end
endmodule // usb_reset_detect
`default_nettype wire

// >>> test/rst_pin_peer.sv
// Purpose: outside party on the shared reset pin
// Assumes: pin has a pull-up, device drives low only
// Notes:   pull_low is the bench asking the party to hold the pin low
`timescale 1ns/1ps
`default_nettype none
module rst_pin_peer (
	input  wire logic oe_n,
	input  wire logic drv,
	input  wire logic pull_low,
	output logic      pin
);
	// wired-and of both pull-downs over the pull-up, so a released pin reads high, never stale
	assign pin = (oe_n | drv) & ~pull_low;
endmodule // rst_pin_peer
`default_nettype wire

// >>> test/reset_seq_props.sv
// Purpose: port-level assertions for the reset sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   drive counter saturates well above the power-on length
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"
module reset_seq_props (
	input wire logic                  CLK,
	input wire logic                  RST_N,
	input wire logic                  PSEL,
	input wire logic                  PENABLE,
	input wire logic                  PWRITE,
	input wire logic [`ADDR_BITS-1:0] PADDR,
	input wire logic                  PREADY,
	input wire logic                  RST_PIN_IN,
	input wire logic                  RST_PIN_OE_N,
	input wire logic                  WDOG_CLEAR,
	input wire logic                  WDOG_DISABLE,
	input wire logic                  MONITOR_MODE,
	input wire logic                  BREAK_STATE,
	input wire logic                  HV_RST_PIN,
	input wire logic                  HV_IRQ_PIN,
	input wire logic                  BAD_OPCODE,
	input wire logic                  INTERNAL_RESET,
	input wire logic                  BUS_CLOCK_EN,
	input wire logic [15:0]           RESET_VECTOR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ----------------------------------------
	// helper: length of the current pin drive
	// ----------------------------------------
	logic [15:0] low_cnt;
	logic        run;
	assign run = BUS_CLOCK_EN && !INTERNAL_RESET;
	always @(posedge CLK) begin
		low_cnt <= (!RST_N || RST_PIN_OE_N) ? 16'h0000 : (low_cnt == 16'hFFFF ? low_cnt : low_cnt + 16'h0001);
	end
	property p_drive; $rose(RST_PIN_OE_N) |-> (low_cnt == 16'h0020 || low_cnt >= 16'h1000); endproperty
	a_drive: assert property (p_drive) else $error("pin drive length wrong");
	property p_hold; $rose(RST_PIN_OE_N) && RST_PIN_IN |-> ##31 INTERNAL_RESET ##1 !INTERNAL_RESET; endproperty
	a_hold: assert property (p_hold) else $error("reset hold after drive wrong");
	property p_opcode; BAD_OPCODE && run |=> INTERNAL_RESET && !RST_PIN_OE_N; endproperty
	a_opcode: assert property (p_opcode) else $error("bad opcode not acted on");
	property p_pin; !RST_PIN_IN && run |=> INTERNAL_RESET; endproperty
	a_pin: assert property (p_pin) else $error("pin low did not halt");
	property p_disable;
		1 |=> WDOG_DISABLE == (($past(MONITOR_MODE) && ($past(HV_RST_PIN) || $past(HV_IRQ_PIN)))
			|| ($past(BREAK_STATE) && $past(HV_RST_PIN)));
	endproperty
	a_disable: assert property (p_disable) else $error("watchdog disable wrong");
	property p_vector; 1 |=> RESET_VECTOR == ($past(MONITOR_MODE) ? 16'hFEFE : 16'hFFFE); endproperty
	a_vector: assert property (p_vector) else $error("reset vector wrong");
	property p_clear; PSEL && PENABLE && PREADY && PWRITE && PADDR == {`IDX_WDOG_SERVICE, 2'b00} |-> ##[1:2] WDOG_CLEAR;
	endproperty
	a_clear: assert property (p_clear) else $error("service write gave no clear");
	property p_ready; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
	a_ready: assert property (p_ready) else $error("bus answer timing wrong");
	c_reset: cover property ($rose(INTERNAL_RESET));
	c_clear: cover property (WDOG_CLEAR);
	c_stop: cover property ($fell(BUS_CLOCK_EN) && !INTERNAL_RESET);
endmodule // reset_seq_props
bind reset_sequencer_prescaler reset_seq_props u_props (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY,
	.RST_PIN_IN, .RST_PIN_OE_N, .WDOG_CLEAR, .WDOG_DISABLE, .MONITOR_MODE, .BREAK_STATE, .HV_RST_PIN, .HV_IRQ_PIN,
	.BAD_OPCODE, .INTERNAL_RESET, .BUS_CLOCK_EN, .RESET_VECTOR);
`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: byte address is the register index shifted by two
// Notes:   reset windows are counted, stop recovery gets a small slack
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defs.vh"
module tb;
	logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, POWER_UP_PULSE = 0, pull_low = 0;
	logic WDOG_OVERFLOW = 0, MONITOR_MODE = 0, BREAK_STATE = 0, HV_RST_PIN = 0, HV_IRQ_PIN = 0, BAD_OPCODE = 0;
	logic STOP_EXEC = 0, STOP_EXIT = 0, FETCH_UNMAPPED = 0, OPCODE_FETCH = 0, USB_DP = 1, USB_DM = 0;
	logic USB_SUSPENDED = 0, USB_ADDRESS_SET = 0, PREADY, PSLVERR, er;
	logic RST_PIN_IN, RST_PIN_OE_N, WDOG_TICK, WDOG_CLEAR, WDOG_DISABLE, USB_UNADDRESSED, USB_WAKE;
	logic INTERNAL_RESET, BUS_CLOCK_EN, RST_PIN_OUT;
	logic [`ADDR_BITS-1:0] PADDR = '0;
	logic [31:0]           PWDATA = '0, PRDATA, rd;
	logic [15:0]           RESET_VECTOR;
	logic [7:0]            exp_cause [6] = '{8'h10, 8'h20, 8'h08, 8'h10, 8'h10, 8'h04};
	int                    exp_oe [6] = '{32, 32, 32, 32, 0, 0};
	int                    exp_ir [6] = '{64, 64, 64, 64, 0, -1};
	int                    num_errors = 0, checks = 0, n_oe, n_ir, k, t;
	localparam logic [17:0] CAUSE_A = {`IDX_RESET_CAUSE, 2'b00};
	localparam logic [17:0] OPT_A = {`IDX_OPTIONS, 2'b00};
	localparam logic [17:0] SVC_A = {`IDX_WDOG_SERVICE, 2'b00};
	localparam logic [17:0] STAT_A = {`IDX_STATUS, 2'b00};
	reset_sequencer_prescaler #(.PIN_POR_CYCLES(`PIN_POR_CYCLES)) DUT (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .POWER_UP_PULSE, .RST_PIN_IN, .RST_PIN_OUT, .RST_PIN_OE_N,
		.WDOG_OVERFLOW, .WDOG_TICK, .WDOG_CLEAR, .WDOG_DISABLE, .MONITOR_MODE, .BREAK_STATE, .HV_RST_PIN,
		.HV_IRQ_PIN, .BAD_OPCODE, .STOP_EXEC, .STOP_EXIT, .FETCH_UNMAPPED, .OPCODE_FETCH, .USB_DP, .USB_DM,
		.USB_SUSPENDED, .USB_ADDRESS_SET, .USB_UNADDRESSED, .USB_WAKE, .INTERNAL_RESET, .BUS_CLOCK_EN, .RESET_VECTOR);
	rst_pin_peer peer (.oe_n(RST_PIN_OE_N), .drv(RST_PIN_OUT), .pull_low(pull_low), .pin(RST_PIN_IN));
	always #50 CLK = ~CLK;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task results;
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task timeout;
		num_errors++;
		$display("BAD %0t wait ran out", $time);
		results();
	endtask
	// read data and error are taken at the edge that sees PREADY, then the request is dropped
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		for (t = 0; t < 20 && PREADY !== 1'b1; t++) @(posedge CLK);
		if (t == 20) timeout();
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask
	task wait_run(input int n);
		for (t = 0; t < n && !(BUS_CLOCK_EN === 1'b1 && INTERNAL_RESET === 1'b0); t++) @(posedge CLK);
		if (t == n) timeout();
	endtask
	task count(input int n);
		n_oe = 0;
		n_ir = 0;
		repeat (n) begin
			@(posedge CLK);
			n_oe += (RST_PIN_OE_N === 1'b0);
			n_ir += (INTERNAL_RESET === 1'b1);
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge CLK);
		RST_N <= 1;
		for (k = 0; k < 6000 && INTERNAL_RESET !== 1'b0; k++) @(posedge CLK);
		chk(k > 4150 && k < 4175, 1);
		apb(0, CAUSE_A, 0); chk(rd, 32'h0000_0080);
		chk(RESET_VECTOR, 16'hFFFE);
		apb(1, CAUSE_A, 32'hFFFF_FFFF); apb(0, CAUSE_A, 0); chk(rd, 32'h0000_0080);
		apb(0, OPT_A, 0); chk(rd, 32'h0000_0000);
		apb(0, 18'h0_0000, 0); chk(er, 1);
		apb(1, SVC_A, 32'h0000_00A5);
		@(posedge CLK) chk(WDOG_CLEAR, 1);
		// only the low nibble survives the service write, so the counter is small here
		apb(0, STAT_A, 0); chk(rd[27:21], 0);
		for (t = 0; t < 5000 && WDOG_TICK !== 1'b1; t++) @(posedge CLK);
		chk(t > 4070 && t < 4100, 1);
		for (k = 0; k < 6; k++) begin
			@(posedge CLK);
			case (k)
				0: BAD_OPCODE <= 1;
				1: WDOG_OVERFLOW <= 1;
				2: {FETCH_UNMAPPED, OPCODE_FETCH} <= 2'h3;
				3: STOP_EXEC <= 1;
				4: FETCH_UNMAPPED <= 1;
				default: {USB_DP, USB_SUSPENDED} <= 2'b01;
			endcase
			// forty cycles of both lines low is a long single-ended zero
			repeat (k == 5 ? 40 : 1) @(posedge CLK);
			if (k == 5) chk(USB_WAKE, 1);
			{BAD_OPCODE, WDOG_OVERFLOW, FETCH_UNMAPPED, OPCODE_FETCH, STOP_EXEC, USB_SUSPENDED, USB_DP} <= 7'h01;
			count(200);
			chk(n_oe, exp_oe[k]);
			if (exp_ir[k] >= 0) chk(n_ir, exp_ir[k]);
			wait_run(500);
			apb(0, CAUSE_A, 0); chk(rd, exp_cause[k]);
		end
		chk(USB_UNADDRESSED, 1);
		@(posedge CLK) USB_ADDRESS_SET <= 1;
		@(posedge CLK) USB_ADDRESS_SET <= 0;
		repeat (2) @(posedge CLK);
		chk(USB_UNADDRESSED, 0);
		@(posedge CLK) pull_low <= 1;
		repeat (70) @(posedge CLK);
		pull_low <= 0;
		wait_run(300);
		apb(0, CAUSE_A, 0); chk(rd, 32'h0000_0040);
		for (k = 0; k < 2; k++) begin
			apb(1, OPT_A, k ? 32'h0000_0002 : 32'h0000_0003);
			@(posedge CLK) STOP_EXEC <= 1;
			@(posedge CLK) STOP_EXEC <= 0;
			@(posedge CLK) STOP_EXIT <= 1;
			chk(BUS_CLOCK_EN, 0);
			@(posedge CLK) STOP_EXIT <= 0;
			for (t = 0; t < 5000 && BUS_CLOCK_EN !== 1'b1; t++) @(posedge CLK);
			chk(k ? (t > 4000 && t < 4200) : (t > 27 && t < 41), 1);
		end
		@(posedge CLK) POWER_UP_PULSE <= 1;
		@(posedge CLK) POWER_UP_PULSE <= 0;
		@(posedge CLK);
		for (k = 0; k < 6000 && INTERNAL_RESET !== 1'b0; k++) @(posedge CLK);
		chk(k > 4150 && k < 4175, 1);
		apb(0, CAUSE_A, 0); chk(rd, 32'h0000_0080);
		for (k = 0; k < 16; k++) begin
			@(posedge CLK);
			{MONITOR_MODE, BREAK_STATE, HV_RST_PIN, HV_IRQ_PIN} <= k[3:0];
			repeat (3) @(posedge CLK);
			chk(WDOG_DISABLE, (k[3] & (k[1] | k[0])) | (k[2] & k[1]));
			chk(RESET_VECTOR, k[3] ? 16'hFEFE : 16'hFFFE);
		end
		results();
	end
endmodule // tb
`default_nettype wire
